// File: valley_skip_counter_softstart.sv
// switch-on control of a quasi-resonant flyback: valley skipping, soft-start, AHB-Lite regs
// assumes analog comparator outputs are asynchronous and pass two flops here
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`include "vsc_map.svh"

module valley_skip_counter_softstart #(
  parameter int EVAL_CYCLES = `VSC_EVAL_CYC,
  parameter int SS_STEP_CYCLES = `VSC_SS_STEP_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic supply_on_i,
  input wire logic valley_sense_i,
  input wire logic fb_above_low_i,
  input wire logic fb_above_high_i,
  input wire logic fb_above_reset_i,
  input wire logic cs_trip_i,
  input wire logic [1:0] high_voltage_input_i,
  output logic gate_o,
  output logic startup_cell_off_o,
  output logic [1:0] cs_limit_step_o,
  output logic softstart_done_o,
  output logic [1:0] fb_threshold_sel_o,
  output logic [2:0] valley_skip_o
);

  localparam int EW = $clog2(EVAL_CYCLES + 1);
  localparam int SW = $clog2(SS_STEP_CYCLES + 1);

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  logic supply_s, xing_s, fb_low_s, fb_high_s, fb_reset_s, cs_trip_s;
  logic [1:0] line_s;
  logic xing_prev_reg;

  // comparators are asynchronous to clk_sys_i, so two flops before any use
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
    end else begin
      meta_reg <= {high_voltage_input_i, cs_trip_i, fb_above_reset_i, fb_above_high_i,
                   fb_above_low_i, valley_sense_i, supply_on_i};
      sync_reg <= meta_reg;
    end
  end
  assign {line_s, cs_trip_s, fb_reset_s, fb_high_s, fb_low_s, xing_s, supply_s} = sync_reg;

  // --------------------------------------------------------------
  // register file over AHB-Lite
  // --------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] ring_reg;
  logic [15:0] offmax_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic addr_ok;
  logic [31:0] status_word;
  logic run;

  vsc_pkg::drive_state_t state_reg;
  logic [2:0] skip_reg;
  logic [2:0] xing_cnt_reg;
  logic [1:0] ss_step_reg;
  logic ss_done_reg;
  logic [15:0] off_cnt_reg;
  logic [15:0] on_cnt_reg;

  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign run = supply_s && ctrl_reg[`VSC_CTRL_EN_BIT];
  assign status_word = {19'h0_0000, xing_cnt_reg, ss_done_reg, ss_step_reg, gate_o,
                        skip_reg, state_reg};
  // zero wait state, every access answered OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // address phase is captured, write data taken in the data phase
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite_i;
      wr_addr_reg <= haddr_i[7:0];
    end
  end

  // writable registers; unmapped writes are dropped
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_reg <= `VSC_CTRL_RESET;
      ring_reg <= 16'(`VSC_RING_CYC);
      offmax_reg <= 16'(`VSC_OFFMAX_CYC);
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `VSC_OFF_CTRL: ctrl_reg <= {31'h0, hwdata_i[`VSC_CTRL_EN_BIT]};
        `VSC_OFF_RING: ring_reg <= hwdata_i[15:0];
        `VSC_OFF_OFFMAX: offmax_reg <= hwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // read data is prepared at the address phase so it stands from a flop in the data phase
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_i) begin
      unique case (haddr_i[7:0])
        `VSC_OFF_CTRL: hrdata_o <= ctrl_reg;
        `VSC_OFF_STATUS: hrdata_o <= status_word;
        `VSC_OFF_RING: hrdata_o <= {16'h0000, ring_reg};
        `VSC_OFF_OFFMAX: hrdata_o <= {16'h0000, offmax_reg};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------
  // evaluation period and valley-skip counter
  // --------------------------------------------------------------
  logic [EW-1:0] eval_cnt_reg;
  logic eval_tick;
  logic seen_low_reg, seen_high_reg;
  logic low_any, high_any;

  assign eval_tick = run && (eval_cnt_reg == EW'(EVAL_CYCLES - 1));
  assign low_any = seen_low_reg || fb_low_s;
  assign high_any = seen_high_reg || fb_high_s;

  // free period timer while running
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run || eval_tick) begin
      eval_cnt_reg <= '0;
    end else begin
      eval_cnt_reg <= eval_cnt_reg + EW'(1);
    end
  end

  // sticky crossing flags; a crossing in the clearing cycle is kept, not lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run) begin
      seen_low_reg <= 1'b0;
      seen_high_reg <= 1'b0;
    end else if (eval_tick) begin
      // set wins over clear: a level seen in the tick cycle also opens the next period
      seen_low_reg <= fb_low_s;
      seen_high_reg <= fb_high_s;
    end else begin
      seen_low_reg <= low_any;
      seen_high_reg <= high_any;
    end
  end

  // counter update; the reset threshold acts at once rather than waiting for the period
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run) begin
      skip_reg <= `VSC_SKIP_MIN;
    end else if (fb_reset_s) begin
      skip_reg <= `VSC_SKIP_MIN;
    end else if (eval_tick) begin
      if (high_any) begin
        if (skip_reg != `VSC_SKIP_MIN) skip_reg <= skip_reg - 3'h1;
      end else if (!low_any) begin
        if (skip_reg != `VSC_SKIP_MAX) skip_reg <= skip_reg + 3'h1;
      end // otherwise hold
    end
  end

  // the analog side shifts its low/high thresholds by the line level code
  assign fb_threshold_sel_o = line_s;
  assign valley_skip_o = skip_reg;
  assign startup_cell_off_o = supply_s;

  // --------------------------------------------------------------
  // soft-start
  // --------------------------------------------------------------
  logic [SW-1:0] ss_cnt_reg;
  logic ss_step_end;

  assign ss_step_end = !ss_done_reg && (ss_cnt_reg == SW'(SS_STEP_CYCLES - 1));

  // four equal steps, the analog limit reads 0.32V at step 0 and 1V at the last
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run) begin
      ss_cnt_reg <= '0;
      ss_step_reg <= 2'h0;
      ss_done_reg <= 1'b0;
    end else if (ss_step_end) begin
      ss_cnt_reg <= '0;
      if (ss_step_reg == `VSC_SS_LAST) ss_done_reg <= 1'b1;
      else ss_step_reg <= ss_step_reg + 2'h1;
    end else if (!ss_done_reg) begin
      ss_cnt_reg <= ss_cnt_reg + SW'(1);
    end
  end
  assign cs_limit_step_o = ss_step_reg;
  assign softstart_done_o = ss_done_reg;

  // --------------------------------------------------------------
  // gate drive
  // --------------------------------------------------------------
  logic turn_on, turn_off;

  assign turn_on = (state_reg == vsc_pkg::ST_OFF) &&
                   (((off_cnt_reg >= ring_reg) && (xing_cnt_reg >= skip_reg)) ||
                    (off_cnt_reg >= offmax_reg));
  // current-sense trip is blanked at the leading edge; long pulses are cut short
  assign turn_off = (state_reg == vsc_pkg::ST_ON) &&
                    ((cs_trip_s && (on_cnt_reg >= 16'(`VSC_LEB_CYC))) ||
                     (on_cnt_reg >= 16'(`VSC_ONMAX_CYC)));

  // off-time and on-time counters, saturating so a stuck switch cannot wrap them
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state_reg != vsc_pkg::ST_OFF) off_cnt_reg <= 16'h0000;
    else if (off_cnt_reg != 16'hffff) off_cnt_reg <= off_cnt_reg + 16'h0001;
    if (rst_i || state_reg != vsc_pkg::ST_ON) on_cnt_reg <= 16'h0000;
    else if (on_cnt_reg != 16'hffff) on_cnt_reg <= on_cnt_reg + 16'h0001;
  end

  // gate state machine
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run) begin
      state_reg <= vsc_pkg::ST_WAIT;
    end else begin
      unique case (state_reg)
        vsc_pkg::ST_WAIT: state_reg <= vsc_pkg::ST_OFF;
        vsc_pkg::ST_OFF: if (turn_on) state_reg <= vsc_pkg::ST_ON;
        vsc_pkg::ST_ON: if (turn_off) state_reg <= vsc_pkg::ST_OFF;
        default: state_reg <= vsc_pkg::ST_WAIT;
      endcase
    end
  end
  assign gate_o = (state_reg == vsc_pkg::ST_ON);

  // zero-crossing counter: rising comparator output marks a falling crossing
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      xing_prev_reg <= 1'b0;
      xing_cnt_reg <= 3'h0;
    end else begin
      xing_prev_reg <= xing_s;
      if (turn_on) xing_cnt_reg <= 3'h0;
      else if (state_reg == vsc_pkg::ST_OFF && xing_s && !xing_prev_reg &&
               xing_cnt_reg != `VSC_XING_MAX)
        xing_cnt_reg <= xing_cnt_reg + 3'h1;
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_gate_rise;
    !gate_o ##1 gate_o;
  endsequence
  sequence s_tick_up;
    eval_tick && !low_any && !high_any && !fb_reset_s && skip_reg != `VSC_SKIP_MAX;
  endsequence

  property p_skip_range;
    skip_reg >= `VSC_SKIP_MIN;
  endproperty
  a_skip_range: assert property (p_skip_range) else $error("valley count left range");
  property p_skip_up;
    s_tick_up |=> skip_reg == $past(skip_reg) + 3'h1;
  endproperty
  a_skip_up: assert property (p_skip_up) else $error("valley count did not rise");
  property p_skip_hold;
    eval_tick && low_any && !high_any && !fb_reset_s && run |=> $stable(skip_reg);
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("valley count moved");
  property p_skip_down;
    eval_tick && high_any && !fb_reset_s && skip_reg > `VSC_SKIP_MIN
      |=> skip_reg == $past(skip_reg) - 3'h1;
  endproperty
  a_skip_down: assert property (p_skip_down) else $error("valley count did not fall");
  property p_skip_force;
    fb_reset_s |=> skip_reg == `VSC_SKIP_MIN;
  endproperty
  a_skip_force: assert property (p_skip_force) else $error("reset level ignored");
  property p_skip_start;
    state_reg == vsc_pkg::ST_WAIT |-> skip_reg == `VSC_SKIP_MIN;
  endproperty
  a_skip_start: assert property (p_skip_start) else $error("start count not one");
  property p_no_tick_between;
    eval_tick |=> !eval_tick [*8];
  endproperty
  a_no_tick_between: assert property (p_no_tick_between) else $error("period too short");
  property p_xing_clear;
    s_gate_rise |-> xing_cnt_reg == 3'h0;
  endproperty
  a_xing_clear: assert property (p_xing_clear) else $error("crossing count not cleared");
  property p_xing_step;
    !gate_o ##1 !gate_o |-> xing_cnt_reg == $past(xing_cnt_reg) ||
                             xing_cnt_reg == $past(xing_cnt_reg) + 3'h1;
  endproperty
  a_xing_step: assert property (p_xing_step) else $error("crossing count jumped");
  property p_on_cause;
    s_gate_rise |-> $past(off_cnt_reg) >= $past(offmax_reg) ||
                    ($past(off_cnt_reg) >= $past(ring_reg) &&
                     $past(xing_cnt_reg) >= $past(skip_reg));
  endproperty
  a_on_cause: assert property (p_on_cause) else $error("gate rose without cause");
  property p_offmax;
    state_reg == vsc_pkg::ST_OFF && off_cnt_reg >= offmax_reg && run |=> gate_o;
  endproperty
  a_offmax: assert property (p_offmax) else $error("maximum off time missed");
  property p_ss_step;
    run && ss_step_end && ss_step_reg != `VSC_SS_LAST
      |=> ss_step_reg == $past(ss_step_reg) + 2'h1;
  endproperty
  a_ss_step: assert property (p_ss_step) else $error("soft-start step lost");
  property p_cell;
    ##2 startup_cell_off_o == $past(supply_on_i, 2);
  endproperty
  a_cell: assert property (p_cell) else $error("charger control wrong");

endmodule // valley_skip_counter_softstart

// File: vsc_map.svh
// named constants of the valley-skip / soft-start controller
// assumes a 10 MHz system clock; included by its bare name
`ifndef VSC_MAP_SVH
`define VSC_MAP_SVH
// clock and times, each in its own unit
`define VSC_CLK_NS 100
`define VSC_EVAL_MS 48
`define VSC_SS_TOTAL_MS 12
`define VSC_SS_STEPS 4
`define VSC_RING_NS 2500
`define VSC_OFFMAX_NS 50000
`define VSC_LEB_NS 300
`define VSC_ONMAX_NS 25000
// derived cycle counts (least times round up, windows round down)
`define VSC_EVAL_CYC ((`VSC_EVAL_MS * 1000000) / `VSC_CLK_NS)
`define VSC_SS_STEP_CYC (((`VSC_SS_TOTAL_MS * 1000000) / `VSC_SS_STEPS) / `VSC_CLK_NS)
`define VSC_RING_CYC ((`VSC_RING_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)
`define VSC_OFFMAX_CYC (`VSC_OFFMAX_NS / `VSC_CLK_NS)
`define VSC_LEB_CYC ((`VSC_LEB_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)
`define VSC_ONMAX_CYC (`VSC_ONMAX_NS / `VSC_CLK_NS)
// counter limits
`define VSC_SKIP_MIN 3'h1
`define VSC_SKIP_MAX 3'h7
`define VSC_XING_MAX 3'h7
`define VSC_SS_LAST 2'h3
// register byte offsets
`define VSC_OFF_CTRL 8'h00
`define VSC_OFF_STATUS 8'h04
`define VSC_OFF_RING 8'h08
`define VSC_OFF_OFFMAX 8'h0c
// field positions and reset values
`define VSC_CTRL_EN_BIT 0
`define VSC_CTRL_RESET 32'h0000_0001
`endif

// File: vsc_pkg.sv
// types of the valley-skip / soft-start controller
// assumes nothing of its surroundings
package vsc_pkg;
  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_ON = 3'h2,
    ST_OFF = 3'h4
  } drive_state_t;
endpackage

// File: vsc_switch_model.sv
// model of the power switch, current-sense comparator and ringing detector
// assumes the bench clock; outputs change just after rising edges only
module vsc_switch_model (
  input wire logic clk_i,
  input wire logic gate_i,
  input wire logic pulse_en_i,
  input wire logic [7:0] pulse_gap_i,
  input wire logic [7:0] trip_delay_i,
  output logic valley_sense_o = 1'b0,
  output logic cs_trip_o = 1'b0
);
  logic [7:0] age_reg = 8'h00;
  logic gate_q_reg = 1'b0;
  // cycles since the last gate edge; saturates so a long off time never wraps
  always_ff @(posedge clk_i) begin
    gate_q_reg <= gate_i;
    if (gate_i != gate_q_reg) begin
      age_reg <= 8'h00;
    end else if (age_reg != 8'hff) begin
      age_reg <= age_reg + 8'h01;
    end
  end
  // ringing after turn-off gives two-cycle pulses; clamped low while the switch conducts
  always_ff @(posedge clk_i) begin
    valley_sense_o <= !gate_i && pulse_en_i && age_reg >= 8'h03 && (age_reg % pulse_gap_i) < 8'h02;
  end
  // sensed current crosses the feedback level trip_delay cycles into the on time
  always_ff @(posedge clk_i) begin
    cs_trip_o <= gate_i && age_reg >= trip_delay_i;
  end
endmodule // vsc_switch_model

// File: valley_skip_counter_softstart_tb.sv
// self-checking bench of the valley-skip and soft-start controller
// assumes short count parameters and the switch model on the comparator side
`include "vsc_map.svh"
module valley_skip_counter_softstart_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EVAL = 64;
  localparam int SS = 16;
  localparam int TRIP = 2;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, supply_on = 1'b0;
  logic fb_low = 1'b0, fb_high = 1'b0, fb_reset = 1'b0, pulse_en = 1'b1;
  logic [1:0] htrans = 2'h0, line_code = 2'h0, ss_step, thr_sel, last_step;
  logic [2:0] hsize = 3'h2, valley, vexp, v0, valley_prev;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h0001_6186;
  logic hreadyout, hresp, valley_sense, cs_trip, gate, cell_off, ss_done, gate_q, vs_q;
  int n_fail = 0, checked = 0, cycles_run = 0, ring_now = 25, offmax_now = 500;
  int off_len = 0, on_len = 0, xings = 0, n_rise = 0, t, k, i, c, old, r0;
  int tch[4];
  bit armed = 1'b0;
  always #50 clk_sys_i = ~clk_sys_i;
  valley_skip_counter_softstart #(.EVAL_CYCLES(EVAL), .SS_STEP_CYCLES(SS)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .supply_on_i(supply_on),
    .valley_sense_i(valley_sense), .fb_above_low_i(fb_low), .fb_above_high_i(fb_high),
    .fb_above_reset_i(fb_reset), .cs_trip_i(cs_trip), .high_voltage_input_i(line_code),
    .gate_o(gate), .startup_cell_off_o(cell_off), .cs_limit_step_o(ss_step),
    .softstart_done_o(ss_done), .fb_threshold_sel_o(thr_sel), .valley_skip_o(valley));
  vsc_switch_model partner (.clk_i(clk_sys_i), .gate_i(gate), .pulse_en_i(pulse_en),
    .pulse_gap_i(8'h06), .trip_delay_i(8'(TRIP)), .valley_sense_o(valley_sense),
    .cs_trip_o(cs_trip));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // one evaluation period of a feedback class: 0 low, 1 between, 2 high, 3 reset
  function automatic logic [2:0] upd(input int cls, input logic [2:0] v);
    if (cls == 3) return 3'h1;
    if (cls == 2) return (v > 3'h1) ? v - 3'h1 : 3'h1;
    if (cls == 1) return v;
    return (v < 3'h7) ? v + 3'h1 : 3'h7;
  endfunction
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // unknown bounds or values compare as x and so count as a mismatch
  task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // single word transfer; waits on hready with no assumed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic complete_run();
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard sized well above the whole sequence
  always @(posedge clk_sys_i) begin
    cycles_run++;
    if (cycles_run == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // switching monitor: judges every on window and every armed off window from the outside
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (gate === 1'b1 && gate_q === 1'b0) begin
      if (armed) begin
        check_range(off_len, ring_now, offmax_now + 4);
        if (off_len < offmax_now) check_range(xings, valley_prev, 255);
        if (pulse_en === 1'b0) check_range(off_len, offmax_now, offmax_now + 4);
      end
      on_len = 0;
      n_rise++;
    end else if (gate === 1'b0 && gate_q === 1'b1) begin
      check_range(on_len, 4, TRIP + 8);
      armed = 1'b1;
      off_len = 0;
      xings = 0;
    end
    if (valley_sense === 1'b1 && vs_q === 1'b0) xings++;
    off_len++;
    on_len++;
    gate_q = gate;
    vs_q = valley_sense;
    valley_prev = valley;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    check_word({gate, valley, ss_step, ss_done, cell_off}, 32'h10);
    bus(1'b0, `VSC_OFF_CTRL, 32'h0);
    check_word(rd, `VSC_CTRL_RESET);
    bus(1'b0, `VSC_OFF_STATUS, 32'h0);
    check_word(rd, 32'h9);
    check_word({hresp, hreadyout}, 32'h1);
    bus(1'b0, `VSC_OFF_RING, 32'h0);
    check_word(rd, 32'h19);
    bus(1'b0, `VSC_OFF_OFFMAX, 32'h0);
    check_word(rd, 32'h1f4);
    bus(1'b1, 8'h10, 32'hffff_ffff);
    bus(1'b0, 8'h10, 32'h0);
    check_word(rd, 32'h0);
    bus(1'b1, `VSC_OFF_RING, 32'h1e);
    ring_now = 30;
    bus(1'b0, `VSC_OFF_RING, 32'h0);
    check_word(rd, 32'h1e);
    // supply crosses its turn-on level: charger off, then soft-start
    @(posedge clk_sys_i);
    supply_on <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    check_word({cell_off, ss_step}, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    #1;
    check_word(cell_off, 32'h1);
    last_step = ss_step;
    k = 0;
    for (t = 0; t < 200 && ss_done !== 1'b1; t++) begin
      @(posedge clk_sys_i);
      #1;
      if (ss_step !== last_step) begin
        if (k < 3) tch[k] = t;
        k++;
        last_step = ss_step;
      end
    end
    tch[3] = t - 1;
    check_word({k, 2'(ss_step)}, {32'd3, 2'h3});
    for (i = 1; i < 4; i++) check_word(tch[i] - tch[i-1], SS);
    // lock onto the evaluation period with the feedback held low
    v0 = valley;
    for (t = 0; t < 100 && valley === v0; t++) begin
      @(posedge clk_sys_i);
      #1;
    end
    vexp = upd(0, v0);
    check_word(valley, vexp);
    repeat (EVAL / 2) @(posedge clk_sys_i);
    // changes land mid-period: first tick sees both classes, second only the new one
    old = 0;
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      c = (i < 4) ? 0 : (i == 4) ? 2 : (i == 7) ? 3 : int'(seed % 32'd3);
      @(posedge clk_sys_i);
      fb_low <= (c > 0);
      fb_high <= (c > 1);
      fb_reset <= (c > 2);
      line_code <= seed[9:8];
      if (c == 3) begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        check_word(valley, 32'h1);
        repeat (2 * EVAL - 6) @(posedge clk_sys_i);
      end else begin
        repeat (2 * EVAL - 1) @(posedge clk_sys_i);
      end
      #1;
      vexp = upd(c, upd((old > c) ? old : c, vexp));
      check_word(valley, vexp);
      check_word(thr_sel, seed[9:8]);
      old = c;
    end
    // dead ringing: only the maximum off time can restart the switch
    // shorten the limit first so no window is judged against a stale one
    bus(1'b1, `VSC_OFF_OFFMAX, 32'h3c);
    offmax_now = 60;
    @(posedge clk_sys_i);
    pulse_en <= 1'b0;
    armed = 1'b0;
    r0 = n_rise;
    for (t = 0; t < 1000 && n_rise < r0 + 3; t++) @(posedge clk_sys_i);
    check_range(n_rise, r0 + 3, r0 + 3);
    complete_run();
  end
endmodule // valley_skip_counter_softstart_tb
